// ===== hdl/tic_capture.sv
// Timer input capture block: four identical channels behind an Avalon-MM slave
//
// Summary of operation
// - Event copies 16-bit timer count into result.
// - Mode picks fall, rise, 4th or 16th rise.
// - Each capture sets the event flag.
// - Flag holds until software clears it.
// - New capture overwrites unread result silently.
// - Port writes on output pin can capture.
// - Four identical channels, each own registers.
// - Prescaler cleared when off, not capturing, reset.
// - Prescaler change keeps counter; spurious capture possible.
`timescale 1ns/1ps
`include "tic_params.svh"

module tic_capture #(
  parameter int NUM_CH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Timebase, synchronous to clk
  input wire logic [15:0] timer_count_pair,
  // Capture pins: pad input, port output value, output enable (low drives)
  input wire logic [NUM_CH-1:0] capture_pin_in,
  input wire logic [NUM_CH-1:0] capture_pin_out,
  input wire logic [NUM_CH-1:0] capture_pin_oe_n,
  // Capture events and flags
  output logic [NUM_CH-1:0] capture_pulse,
  output logic [NUM_CH-1:0] capture_event_flag
);

  if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_num_ch
    $error("NUM_CH must be 1 to 4");
  end

  // ****************************************
  // Bus state
  // ****************************************
  typedef struct packed {
    tic_pkg::tic_bus_state_t fsm;
    logic [31:0] rdata;
  } tic_bus_t;

  tic_bus_t bus_reg;
  tic_bus_t bus_next;

  tic_pkg::tic_chan_t chan [NUM_CH];
  logic [NUM_CH-1:0] pin_level;
  logic [NUM_CH-1:0] mode_we;
  logic [NUM_CH-1:0] flag_clr;
  logic [1:0] ch_sel;
  logic [3:0] reg_off;
  logic take;
  logic commit;

  assign ch_sel = avs_address[5:4];
  assign reg_off = avs_address[3:0];
  // Single wait state: request is taken in IDLE, answered in ACK
  assign take = (bus_reg.fsm == tic_pkg::TIC_BUS_IDLE) && (avs_read || avs_write);
  // Writes land only at the edge where the master sees waitrequest low
  assign commit = (bus_reg.fsm == tic_pkg::TIC_BUS_ACK) && avs_write;
  assign avs_waitrequest = !(bus_reg.fsm == tic_pkg::TIC_BUS_ACK);
  assign avs_readdata = bus_reg.rdata;

  // ****************************************
  // Channels
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      // A driven pin follows the port value, so a port write can make an edge
      assign pin_level[gi] = capture_pin_oe_n[gi] ? capture_pin_in[gi] :
                             capture_pin_out[gi];
      assign mode_we[gi] = commit && (ch_sel == 2'(gi)) &&
                           (reg_off == `TIC_OFF_CTRL) && avs_byteenable[0];
      // Write one to clear
      assign flag_clr[gi] = commit && (ch_sel == 2'(gi)) &&
                            (reg_off == `TIC_OFF_FLAG) && avs_byteenable[0] &&
                            avs_writedata[0];
      tic_channel u_ch (
        .clk(clk),
        .srst(srst),
        .pin_level(pin_level[gi]),
        .timer_count_pair(timer_count_pair),
        .mode_wdata(avs_writedata[`TIC_MODE_LSB +: `TIC_MODE_W]),
        .mode_we(mode_we[gi]),
        .flag_clr(flag_clr[gi]),
        .chan(chan[gi]),
        .capture_pulse(capture_pulse[gi])
      );
      assign capture_event_flag[gi] = chan[gi].flag;
    end
  endgenerate

  // ****************************************
  // Register read and handshake
  // ****************************************
  always_comb begin
    bus_next = bus_reg;
    case (bus_reg.fsm)
      tic_pkg::TIC_BUS_IDLE: begin
        if (take) begin
          bus_next.fsm = tic_pkg::TIC_BUS_ACK;
          bus_next.rdata = 32'h0000_0000;
          // Unmapped channel or offset reads zero, writes are dropped
          if (avs_read && (32'(ch_sel) < NUM_CH)) begin
            case (reg_off)
              `TIC_OFF_CTRL: begin
                bus_next.rdata = {28'h0, chan[ch_sel].mode};
              end
              `TIC_OFF_RESULT: begin
                bus_next.rdata = {16'h0, chan[ch_sel].result};
              end
              `TIC_OFF_FLAG: begin
                bus_next.rdata = {31'h0, chan[ch_sel].flag};
              end
              `TIC_OFF_PRESC: begin
                bus_next.rdata = {28'h0, chan[ch_sel].presc};
              end
              default: begin
                bus_next.rdata = 32'h0000_0000;
              end
            endcase
          end
        end
      end
      tic_pkg::TIC_BUS_ACK: begin
        bus_next.fsm = tic_pkg::TIC_BUS_IDLE;
      end
      default: begin
        bus_next.fsm = tic_pkg::TIC_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bus_reg <= '0;
    end else begin
      bus_reg <= bus_next;
    end
  end

endmodule // tic_capture

// ===== include/tic_params.svh
// Constants for the timer input capture block
`ifndef TIC_PARAMS_SVH
`define TIC_PARAMS_SVH

// ****************************************
// Register map (32-bit words, byte addresses)
// ****************************************
`define TIC_OFF_CTRL 4'h0
`define TIC_OFF_RESULT 4'h4
`define TIC_OFF_FLAG 4'h8
`define TIC_OFF_PRESC 4'hc

// ****************************************
// Field layout and reset values
// ****************************************
`define TIC_MODE_LSB 0
`define TIC_MODE_W 4
`define TIC_CTRL_RST 4'h0
`define TIC_RESULT_RST 16'h0000

// ****************************************
// Mode encodings of capture_mode_select
// ****************************************
`define TIC_MODE_OFF 4'h0
`define TIC_MODE_FALL 4'h4
`define TIC_MODE_RISE 4'h5
`define TIC_MODE_RISE4 4'h6
`define TIC_MODE_RISE16 4'h7

// ****************************************
// Prescaler counts
// ****************************************
`define TIC_DIV4_LAST 4'h3
`define TIC_DIV16_LAST 4'hf

`endif

// ===== include/tic_pkg.sv
// Types for the timer input capture block
package tic_pkg;

  typedef enum logic [1:0] {
    TIC_BUS_IDLE = 2'b00,
    TIC_BUS_ACK = 2'b01
  } tic_bus_state_t;

  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } tic_avm_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } tic_avm_rsp_t;

  typedef struct packed {
    logic [3:0] mode;
    logic [15:0] result;
    logic flag;
    logic [3:0] presc;
  } tic_chan_t;

endpackage

// ===== hdl/tic_channel.sv
// One capture channel: edge detect, prescaler, result pair and event flag
`timescale 1ns/1ps
`include "tic_params.svh"

module tic_channel (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Capture pin, level as seen at the pad
  input wire logic pin_level,
  // Timebase
  input wire logic [15:0] timer_count_pair,
  // Software control
  input wire logic [3:0] mode_wdata,
  input wire logic mode_we,
  input wire logic flag_clr,
  // State
  output tic_pkg::tic_chan_t chan,
  output logic capture_pulse
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic last;
    tic_pkg::tic_chan_t ch;
    logic cap;
  } tic_ch_state_t;

  tic_ch_state_t st_reg;
  tic_ch_state_t st_next;

  logic rise;
  logic fall;
  logic capturing;
  logic event_hit;

  always_comb begin
    st_next = st_reg;
    // Only sync2 is compared against its previous copy
    rise = st_reg.sync2 & ~st_reg.last;
    fall = ~st_reg.sync2 & st_reg.last;
    capturing = (st_reg.ch.mode == `TIC_MODE_FALL) || (st_reg.ch.mode == `TIC_MODE_RISE) ||
                (st_reg.ch.mode == `TIC_MODE_RISE4) || (st_reg.ch.mode == `TIC_MODE_RISE16);
    event_hit = 1'b0;
    st_next.sync1 = pin_level;
    st_next.sync2 = st_reg.sync1;
    st_next.last = st_reg.sync2;
    case (st_reg.ch.mode)
      `TIC_MODE_FALL: begin
        event_hit = fall;
      end
      `TIC_MODE_RISE: begin
        event_hit = rise;
      end
      `TIC_MODE_RISE4: begin
        event_hit = rise && (st_reg.ch.presc[1:0] == `TIC_DIV4_LAST);
      end
      `TIC_MODE_RISE16: begin
        event_hit = rise && (st_reg.ch.presc == `TIC_DIV16_LAST);
      end
      default: begin
        event_hit = 1'b0;
      end
    endcase
    // Counter keeps running across prescaler changes, so a switch may fire early
    if (!capturing) begin
      st_next.ch.presc = 4'h0;
    end else if (rise) begin
      st_next.ch.presc = st_reg.ch.presc + 4'h1;
    end
    if (event_hit) begin
      st_next.ch.result = timer_count_pair;
    end
    st_next.cap = event_hit;
    // Set wins over a clear in the same cycle
    if (event_hit) begin
      st_next.ch.flag = 1'b1;
    end else if (flag_clr) begin
      st_next.ch.flag = 1'b0;
    end
    if (mode_we) begin
      st_next.ch.mode = mode_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign chan = st_reg.ch;
  assign capture_pulse = st_reg.cap;

endmodule // tic_channel

// ===== dv/tic_src.sv
// Signal source model driving the capture pads
`timescale 1ns/1ps
module tic_src (
  // Pad levels
  output logic [3:0] lvl
);
  initial lvl = 4'h0;
  // Called right after an edge, so each level holds whole cycles
  task automatic drive(input int c, input logic v);
    lvl[c] <= v;
  endtask
endmodule // tic_src

// ===== dv/tic_capture_asserts.sv
// Port checker for the capture block
`timescale 1ns/1ps
module tic_capture_asserts #(
  parameter int NUM_CH = 4
) (
  // Clock, reset and bus
  input wire logic clk,
  input wire logic srst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  // Capture side
  input wire logic [NUM_CH-1:0] capture_pin_in,
  input wire logic [NUM_CH-1:0] capture_pin_out,
  input wire logic [NUM_CH-1:0] capture_pin_oe_n,
  input wire logic [NUM_CH-1:0] capture_pulse,
  input wire logic [NUM_CH-1:0] capture_event_flag
);
  logic seen;
  logic clr;
  assign seen = capture_pin_oe_n[0] ? capture_pin_in[0] : capture_pin_out[0];
  assign clr = avs_write && !avs_waitrequest && avs_address == 6'h08 && avs_writedata[0]
    && avs_byteenable[0];
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  AST_ACK_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("ack late");
  AST_ACK_SHORT: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("ack long");
  AST_PULSE_ONE: assert property (capture_pulse[0] |=> !capture_pulse[0])
    else $error("pulse wide");
  AST_PIN_PULSE: assert property (capture_pulse[0] |-> $past(seen, 3) != $past(seen, 4))
    else $error("pulse without edge");
  AST_FLAG_SET: assert property (capture_pulse[0] |-> capture_event_flag[0])
    else $error("flag not set");
  AST_FLAG_RISE: assert property ($rose(capture_event_flag[0]) |-> capture_pulse[0])
    else $error("flag rose alone");
  AST_FLAG_HOLD: assert property (capture_event_flag[0] && !clr |=> capture_event_flag[0])
    else $error("flag dropped");
  AST_FLAG_CLR: assert property (clr |=> !capture_event_flag[0] || capture_pulse[0])
    else $error("flag not cleared");
endmodule // tic_capture_asserts

bind tic_capture tic_capture_asserts #(.NUM_CH(NUM_CH)) u_asserts (.clk, .srst, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .capture_pin_in,
  .capture_pin_out, .capture_pin_oe_n, .capture_pulse, .capture_event_flag);

// ===== dv/tb.sv
// Self-checking bench for the capture block
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] tm = 16'h0;
  logic [3:0] pin_in;
  logic [3:0] pin_out = 4'h0;
  logic [3:0] pin_oe_n = 4'h7;
  logic [3:0] pulse;
  logic [3:0] flag;
  logic [31:0] q;
  int bad_count = 0;
  int checks_done = 0;
  int md[4], pc[4], er[4];
  bit ef[4], lv[4];
  always #12.5 clk = ~clk;
  // Timebase runs on the bench clock, never asynchronously
  always @(posedge clk) tm <= tm + 16'h1;
  tic_src u_src (.lvl(pin_in));
  tic_capture u_dut (.clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest, .timer_count_pair(tm),
    .capture_pin_in(pin_in), .capture_pin_out(pin_out), .capture_pin_oe_n(pin_oe_n),
    .capture_pulse(pulse), .capture_event_flag(flag));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input bit w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      chk(1, 0);
      finish_test();
    end
    // One edge passes so a following call never re-raises a strobe in this step
    @(posedge clk);
  endtask
  task automatic set_mode(input int c, input int m);
    bus(1, 6'(c * 16), 32'(m));
    md[c] = m;
    if (m < 4 || m > 7) pc[c] = 0;
    bus(0, 6'(c * 16), 0);
    chk(q, m);
    bus(1, 6'(c * 16 + 8), 32'h1);
    ef[c] = 0;
  endtask
  task automatic pin_edge(input int c);
    bit ev;
    lv[c] = !lv[c];
    // The side that the pin mux ignores gets noise that must never capture
    if (!pin_oe_n[c]) begin
      pin_out[c] <= lv[c];
      u_src.drive(c, 1'($urandom));
    end else begin
      u_src.drive(c, lv[c]);
      pin_out[c] <= 1'($urandom);
    end
    ev = 0;
    if (md[c] >= 4 && md[c] <= 7) begin
      if (lv[c]) begin
        ev = md[c] == 5 || (md[c] == 6 && pc[c] % 4 == 3) || (md[c] == 7 && pc[c] == 15);
        pc[c] = (pc[c] + 1) % 16;
      end else ev = md[c] == 4;
    end
    if (ev) begin
      er[c] = (tm + 3) % 65536;
      ef[c] = 1;
    end
    repeat (6) @(posedge clk);
    chk(flag[c], ef[c]);
    bus(0, 6'(c * 16 + 4), 0);
    chk(q, er[c]);
    bus(0, 6'(c * 16 + 12), 0);
    chk(q, pc[c]);
  endtask
  initial begin
    int m;
    void'($urandom(93));
    tm <= 16'($urandom);
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    bus(0, 6'h34, 0);
    chk(q, 0);
    bus(0, 6'h02, 0);
    chk(q, 0);
    for (int c = 0; c < 4; c++) begin
      // Both pin sides are still low here, so the switch makes no edge
      pin_oe_n[c] <= 1'($urandom);
      for (int i = 0; i < 5; i++) begin
        m = (i == 4) ? $urandom % 12 : 4 + (i + c) % 4;
        if (i == 4 && m > 3) m = m + 4;
        set_mode(c, m);
        repeat (2 * (2 + $urandom % 12)) pin_edge(c);
      end
      $display("test channel %0d done", c);
    end
    // Leave a counted rise behind, then reset in mid-run
    set_mode(0, 6);
    pin_edge(0);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int c = 0; c < 4; c++) begin
      bus(0, 6'(c * 16 + 12), 0);
      chk(q, 0);
      bus(0, 6'(c * 16 + 4), 0);
      chk(q, 0);
      chk(flag[c], 0);
    end
    $display("test mid-run reset done");
    finish_test();
  end
endmodule // tb
